// ==== hdl/ethernet_mac_control_pkg.sv ====
// Constants shared by the Ethernet control block and its link engine
package ethernet_mac_control_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register byte addresses
	localparam logic [7:0] CONTROL_ONE_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h10;
	localparam logic [7:0] STATION_MIDDLE_ADDR = 8'h20;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h30;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h40;
	localparam logic [7:0] ALIAS_CLR = 8'h04;
	localparam logic [7:0] ALIAS_SET = 8'h08;
	localparam logic [7:0] ALIAS_INV = 8'h0C;
	localparam logic [7:0] ALIAS_MASK = 8'h0C;
	// Control register fields
	localparam int PAUSE_LSB = 16;
	localparam int PAUSE_W = 16;
	localparam int ENABLE_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int TX_REQ_BIT = 9;
	localparam int RX_EN_BIT = 8;
	localparam logic [31:0] CONTROL_ONE_WMASK = 32'hFFFF_A300;
	localparam logic [31:0] CONTROL_ONE_RESET = 32'h0000_0000;
	// Status fields
	localparam int RX_BUSY_BIT = 5;
	localparam int TX_BUSY_BIT = 6;
	// Station address
	localparam int STATION_W = 16;
	localparam logic [15:0] STATION_FACTORY_DEFAULT = 16'h0000;
	// Interrupt status bits
	localparam int IRQ_TX_DONE = 0;
	localparam int IRQ_RX_DONE = 1;
	localparam int IRQ_RX_ABORT = 2;
	localparam int IRQ_W = 3;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_LAST = 2'b10
	} tx_state_e;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_BUSY = 2'b01,
		RX_STORE = 2'b10
	} rx_state_e;
endpackage

// ==== hdl/link_ctrl_if.sv ====
// Control and status between the register block and the link engine
`timescale 1ns/1ps
interface link_ctrl_if;
	logic enable;
	logic paused;
	logic tx_request;
	logic rx_enable;
	logic tx_active;
	logic tx_done;
	logic rx_active;
	logic rx_done;
	logic rx_abort;
	modport regs (output enable, paused, tx_request, rx_enable,
		input tx_active, tx_done, rx_active, rx_done, rx_abort);
	modport engine (input enable, paused, tx_request, rx_enable,
		output tx_active, tx_done, rx_active, rx_done, rx_abort);
endinterface

// ==== hdl/mac_link_engine.sv ====
// Transmit and receive sequencing toward the line side
`timescale 1ns/1ps
module mac_link_engine
	import ethernet_mac_control_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	link_ctrl_if.engine ctl,
	input wire logic tx_descriptor_valid_i,
	input wire logic tx_packet_end_i,
	output logic tx_packet_start_o,
	input wire logic rx_frame_start_i,
	input wire logic rx_frame_end_i,
	input wire logic rx_frame_abort_i,
	input wire logic rx_filter_pass_i,
	output logic rx_store_o
);
	tx_state_e tx_q;
	rx_state_e rx_q;
	logic go;
	assign go = ctl.enable && !ctl.paused;
	// Transmit: walk descriptors while requested
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tx_q <= TX_IDLE;
		end else if (!ctl.enable) begin
			tx_q <= TX_IDLE;
		end else begin
			case (tx_q)
				TX_IDLE: begin
					if (go && ctl.tx_request && tx_descriptor_valid_i) begin
						tx_q <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_packet_end_i) begin
						// Software stop lets the current packet finish first
						tx_q <= ctl.tx_request ? TX_IDLE : TX_LAST;
					end
				end
				TX_LAST: tx_q <= TX_IDLE;
				default: tx_q <= TX_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tx_packet_start_o <= 1'b0;
		end else begin
			tx_packet_start_o <= ctl.enable && tx_q == TX_IDLE && go && ctl.tx_request
				&& tx_descriptor_valid_i;
		end
	end
	assign ctl.tx_active = tx_q != TX_IDLE;
	// Done when table is exhausted while still requested
	assign ctl.tx_done = ctl.enable && tx_q == TX_IDLE && ctl.tx_request
		&& !tx_descriptor_valid_i && !ctl.paused;
	// Receive
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rx_q <= RX_IDLE;
		end else if (!ctl.enable) begin
			rx_q <= RX_IDLE;
		end else begin
			case (rx_q)
				RX_IDLE: begin
					if (go && ctl.rx_enable && rx_frame_start_i) begin
						rx_q <= RX_BUSY;
					end
				end
				RX_BUSY: begin
					if (rx_frame_abort_i || !ctl.rx_enable) begin
						rx_q <= RX_IDLE;
					end else if (rx_frame_end_i) begin
						rx_q <= rx_filter_pass_i ? RX_STORE : RX_IDLE;
					end
				end
				RX_STORE: rx_q <= RX_IDLE;
				default: rx_q <= RX_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rx_store_o <= 1'b0;
		end else begin
			rx_store_o <= ctl.enable && rx_q == RX_BUSY && rx_frame_end_i
				&& rx_filter_pass_i && !rx_frame_abort_i && ctl.rx_enable;
		end
	end
	assign ctl.rx_active = ctl.enable && rx_q == RX_BUSY;
	assign ctl.rx_done = rx_q == RX_STORE;
	assign ctl.rx_abort = rx_q == RX_BUSY && (rx_frame_abort_i || (rx_frame_end_i
		&& !rx_filter_pass_i));
endmodule

// ==== hdl/ethernet_mac_control.sv ====
// Ethernet controller control and status registers
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ethernet_mac_control
	import ethernet_mac_control_pkg::*;
#(
	parameter logic [15:0] STATION_FACTORY = STATION_FACTORY_DEFAULT
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] byte_en_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [31:0] rdata_o,
	input wire logic system_idle_i,
	input wire logic tx_descriptor_valid_i,
	input wire logic tx_packet_end_i,
	output logic tx_packet_start_o,
	input wire logic rx_frame_start_i,
	input wire logic rx_frame_end_i,
	input wire logic rx_frame_abort_i,
	input wire logic rx_filter_pass_i,
	output logic rx_store_o,
	output logic [15:0] pause_time_value_o,
	output logic irq_o
);
	link_ctrl_if ctl ();
	logic [31:0] control_q;
	logic [STATION_W-1:0] station_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [7:0] base;
	logic [7:0] alias_sel;
	logic [31:0] byte_mask;
	logic size_ok;
	logic [IRQ_W-1:0] events;

	assign base = addr_i & ~ALIAS_MASK;
	assign alias_sel = addr_i & ALIAS_MASK;

	// Byte enables widened to a bit mask
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign byte_mask[g*8 +: 8] = {8{byte_en_i[g]}};
		end
	endgenerate

	// Only half-word or word lanes count as a legal station access
	assign size_ok = byte_en_i == 4'hF || byte_en_i == 4'h3 || byte_en_i == 4'hC;

	function automatic logic [31:0] apply(input logic [31:0] cur, input logic [31:0] wd,
		input logic [31:0] m, input logic [7:0] sel);
		logic [31:0] r;
		r = cur;
		case (sel)
			ALIAS_CLR: r = cur & ~(wd & m);
			ALIAS_SET: r = cur | (wd & m);
			ALIAS_INV: r = cur ^ (wd & m);
			default: r = (cur & ~m) | (wd & m);
		endcase
		return r;
	endfunction

	// Control register
	logic [31:0] control_w;
	assign control_w = apply(control_q, wdata_i, byte_mask & CONTROL_ONE_WMASK, alias_sel);
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			control_q <= CONTROL_ONE_RESET;
		end else if (write_i && base == CONTROL_ONE_ADDR) begin
			control_q <= control_w;
		end else if (ctl.tx_done) begin
			// Done clears only when no write touches the register this cycle
			control_q[TX_REQ_BIT] <= 1'b0;
		end
	end

	// Station address, preloaded then writable
	// Held in the register itself so aliased writes act on the factory value
	logic [31:0] station_w;
	assign station_w = apply({16'h0000, station_q}, wdata_i, byte_mask, alias_sel);
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			station_q <= STATION_FACTORY;
		end else if (write_i && base == STATION_MIDDLE_ADDR && size_ok) begin
			station_q <= station_w[STATION_W-1:0];
		end
	end

	// Link control
	assign ctl.enable = control_q[ENABLE_BIT];
	assign ctl.paused = control_q[IDLE_STOP_BIT] && system_idle_i;
	assign ctl.tx_request = control_q[TX_REQ_BIT];
	assign ctl.rx_enable = control_q[RX_EN_BIT];
	assign pause_time_value_o = control_q[PAUSE_LSB +: PAUSE_W];

	mac_link_engine u_engine (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.ctl(ctl.engine),
		.tx_descriptor_valid_i(tx_descriptor_valid_i),
		.tx_packet_end_i(tx_packet_end_i),
		.tx_packet_start_o(tx_packet_start_o),
		.rx_frame_start_i(rx_frame_start_i),
		.rx_frame_end_i(rx_frame_end_i),
		.rx_frame_abort_i(rx_frame_abort_i),
		.rx_filter_pass_i(rx_filter_pass_i),
		.rx_store_o(rx_store_o)
	);

	// Interrupts: sticky, write one to clear, set wins
	logic tx_done_q;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			tx_done_q <= 1'b0;
		end else begin
			tx_done_q <= ctl.tx_done && !(write_i && base == CONTROL_ONE_ADDR);
		end
	end
	assign events[IRQ_TX_DONE] = tx_done_q;
	assign events[IRQ_RX_DONE] = ctl.rx_done;
	assign events[IRQ_RX_ABORT] = ctl.rx_abort;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_status_q <= '0;
		end else if (write_i && addr_i == IRQ_STATUS_ADDR) begin
			irq_status_q <= (irq_status_q & ~wdata_i[IRQ_W-1:0]) | events;
		end else begin
			irq_status_q <= irq_status_q | events;
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_mask_q <= '0;
		end else if (write_i && addr_i == IRQ_MASK_ADDR) begin
			irq_mask_q <= wdata_i[IRQ_W-1:0];
		end
	end
	assign irq_o = |(irq_status_q & irq_mask_q);

	// Read path, data one cycle after the strobe
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		case (base)
			CONTROL_ONE_ADDR: rd_d = control_q & CONTROL_ONE_WMASK;
			STATUS_ADDR: begin
				rd_d[RX_BUSY_BIT] = ctl.rx_active;
				rd_d[TX_BUSY_BIT] = ctl.tx_active;
			end
			STATION_MIDDLE_ADDR: rd_d = {16'h0000, station_q};
			IRQ_STATUS_ADDR: rd_d[IRQ_W-1:0] = irq_status_q;
			IRQ_MASK_ADDR: rd_d[IRQ_W-1:0] = irq_mask_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (read_i) begin
			rdata_o <= rd_d;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end
endmodule

// ==== sim/ethernet_mac_control_props.sv ====
// Port-level assertions for the Ethernet control block
`timescale 1ns/1ps
module ethernet_mac_control_props (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] byte_en_i,
	input wire logic write_i,
	input wire logic read_i,
	input wire logic [31:0] rdata_o,
	input wire logic tx_descriptor_valid_i,
	input wire logic rx_frame_end_i,
	input wire logic rx_filter_pass_i,
	input wire logic tx_packet_start_o,
	input wire logic rx_store_o,
	input wire logic [15:0] pause_time_value_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	wire ctl_wr = write_i && addr_i == 8'h00 && byte_en_i == 4'hF;
	pause_follows_a: assert property (ctl_wr
		|=> pause_time_value_o == $past(wdata_i[31:16]))
		else $error("pause value did not follow control write");
	pause_stable_a: assert property ((!write_i) [*3] |-> $stable(pause_time_value_o))
		else $error("pause value moved without a write");
	start_needs_desc_a: assert property (tx_packet_start_o |-> $past(tx_descriptor_valid_i))
		else $error("packet start without pending descriptor");
	start_pulse_a: assert property (tx_packet_start_o |=> !tx_packet_start_o)
		else $error("packet start longer than one cycle");
	store_needs_pass_a: assert property (rx_store_o |-> $past(rx_frame_end_i && rx_filter_pass_i))
		else $error("frame stored without passing end");
	stop_no_start_a: assert property (ctl_wr && !(wdata_i[15] && wdata_i[9])
		|=> ##1 (!tx_packet_start_o) [*4])
		else $error("packet started after request or enable cleared");
	off_no_store_a: assert property (ctl_wr && !wdata_i[15] |=> ##1 (!rx_store_o) [*4])
		else $error("frame stored while module off");
	station_upper_a: assert property ($past(read_i) && $past(addr_i) == 8'h20
		|-> rdata_o[31:16] == 16'h0000)
		else $error("station upper half not zero");
	cover property (tx_packet_start_o);
	cover property (rx_store_o);
	cover property (ctl_wr && wdata_i[15] && !wdata_i[9]);
endmodule

// ==== sim/line_side_model.sv ====
// Line-side transceiver model: ends packets, sends receive frames
`timescale 1ns/1ps
module line_side_model (
	input wire logic clk_sys_i,
	input wire logic tx_packet_start_i,
	output logic tx_descriptor_valid_o,
	output logic tx_packet_end_o,
	output logic rx_frame_start_o,
	output logic rx_frame_end_o,
	output logic rx_frame_abort_o,
	output logic rx_filter_pass_o
);
	int pending = 0;
	int sent = 0;
	int lat = 1;
	int left = 0;
	assign tx_descriptor_valid_o = pending > 0;
	initial begin
		tx_packet_end_o = 1'b0;
		rx_frame_start_o = 1'b0;
		rx_frame_end_o = 1'b0;
		rx_frame_abort_o = 1'b0;
		rx_filter_pass_o = 1'b0;
	end
	// Packet occupies the line for lat cycles, then one end pulse
	always @(posedge clk_sys_i) begin
		tx_packet_end_o <= 1'b0;
		if (tx_packet_start_i && left == 0) begin
			pending <= pending - 1;
			sent <= sent + 1;
			left <= lat;
		end else if (left == 1) begin
			tx_packet_end_o <= 1'b1;
			left <= 0;
		end else if (left > 1)
			left <= left - 1;
	end
	task automatic frame(input logic pass, input logic abort, input int len);
		@(posedge clk_sys_i);
		rx_frame_start_o <= 1'b1;
		@(posedge clk_sys_i);
		rx_frame_start_o <= 1'b0;
		repeat (len) @(posedge clk_sys_i);
		rx_filter_pass_o <= pass;
		rx_frame_end_o <= !abort;
		rx_frame_abort_o <= abort;
		@(posedge clk_sys_i);
		rx_frame_end_o <= 1'b0;
		rx_frame_abort_o <= 1'b0;
		// Released verdict shows the inverse, never a kept value
		rx_filter_pass_o <= !pass;
	endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the Ethernet control block
`timescale 1ns/1ps
module tb_top;
	import ethernet_mac_control_pkg::*;
	localparam logic [15:0] FACTORY = 16'hA5C3;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic [3:0] byte_en_i = 4'h0;
	logic write_i = 1'b0;
	logic read_i = 1'b0;
	logic system_idle_i = 1'b0;
	logic tx_descriptor_valid_i, tx_packet_end_i, rx_frame_start_i, rx_frame_end_i;
	logic rx_frame_abort_i, rx_filter_pass_i, tx_packet_start_o, rx_store_o, irq_o;
	logic [31:0] rdata_o, v, d;
	logic [15:0] pause_time_value_o, st;
	logic [3:0] bes [4] = '{4'h1, 4'h3, 4'hC, 4'hF};
	int n, stored = 0, mismatches = 0, tests_run = 0, seed = 55;
	always #20 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (rx_store_o === 1'b1) stored++;
	ethernet_mac_control #(.STATION_FACTORY(FACTORY)) dut (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .byte_en_i(byte_en_i),
		.write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .system_idle_i(system_idle_i),
		.tx_descriptor_valid_i(tx_descriptor_valid_i), .tx_packet_end_i(tx_packet_end_i),
		.tx_packet_start_o(tx_packet_start_o), .rx_frame_start_i(rx_frame_start_i),
		.rx_frame_end_i(rx_frame_end_i), .rx_frame_abort_i(rx_frame_abort_i),
		.rx_filter_pass_i(rx_filter_pass_i), .rx_store_o(rx_store_o),
		.pause_time_value_o(pause_time_value_o), .irq_o(irq_o));
	line_side_model phy (.clk_sys_i(clk_sys_i), .tx_packet_start_i(tx_packet_start_o),
		.tx_descriptor_valid_o(tx_descriptor_valid_i), .tx_packet_end_o(tx_packet_end_i),
		.rx_frame_start_o(rx_frame_start_i), .rx_frame_end_o(rx_frame_end_i),
		.rx_frame_abort_o(rx_frame_abort_i), .rx_filter_pass_o(rx_filter_pass_i));
	function automatic logic [15:0] st_exp(logic [15:0] s, logic [15:0] w, logic [3:0] b, int al);
		// Byte-wide and upper-half writes leave the octets alone
		if (b != 4'hF && b != 4'h3) return s;
		case (al)
			0: return w;
			4: return s & ~w;
			8: return s | w;
			default: return s ^ w;
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic [3:0] b);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= w;
		byte_en_i <= b;
		write_i <= 1'b1;
		@(posedge clk_sys_i);
		write_i <= 1'b0;
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		addr_i <= a;
		read_i <= 1'b1;
		@(posedge clk_sys_i);
		read_i <= 1'b0;
		#1 v = rdata_o;
		chk(nm, e, v);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_until(input int want);
		// Waits up to 400 cycles for the sent count; a timeout counts a mismatch and ends the run
		for (int i = 0; i < 400; i++) begin
			if (phy.sent >= want)
				return;
			@(posedge clk_sys_i);
		end
		mismatches++;
		tally_and_finish;
	endtask
	task automatic tx_run(input int cnt, input logic [31:0] ctl);
		phy.sent = 0;
		phy.pending = cnt;
		wr(8'h00, ctl, 4'hF);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rchk("control", 8'h00, 32'h0);
		rchk("station", 8'h20, {16'h0, FACTORY});
		rchk("status", 8'h10, 32'h0);
		rchk("unmapped", 8'h50, 32'h0);
		wr(8'h00, 32'h0000_5CFF, 4'hF);
		rchk("control", 8'h00, 32'h0);
		st = FACTORY;
		for (int i = 0; i < 16; i++) begin
			d = $random(seed);
			wr(8'h20 | 8'(i / 4 * 4), d, bes[i % 4]);
			st = st_exp(st, d[15:0], bes[i % 4], i / 4 * 4);
			rchk("station", 8'h20, {16'h0, st});
		end
		d = ($random(seed) & 32'hFFFF_0000) | 32'h0000_8000;
		wr(8'h00, d, 4'hF);
		rchk("control", 8'h00, d);
		chk("pause", {16'h0, d[31:16]}, {16'h0, pause_time_value_o});
		system_idle_i <= 1'b1;
		n = $unsigned($random(seed)) % 4 + 1;
		phy.lat = $unsigned($random(seed)) % 5 + 1;
		tx_run(n, 32'h0000_8200);
		wait_until(n);
		repeat (20) @(posedge clk_sys_i);
		rchk("control", 8'h00, 32'h0000_8000);
		chk("sent", n, phy.sent);
		chk("irq", 0, irq_o);
		rchk("irq status", 8'h30, 32'h1);
		wr(8'h40, 32'h1, 4'hF);
		chk("irq", 1, irq_o);
		wr(8'h30, 32'h1, 4'hF);
		chk("irq", 0, irq_o);
		phy.lat = 6;
		tx_run(3, 32'h0000_8200);
		wait_until(1);
		wr(8'h00, 32'h0000_8000, 4'hF);
		repeat (20) @(posedge clk_sys_i);
		chk("sent", 1, phy.sent);
		chk("irq", 0, irq_o);
		tx_run(1, 32'h0000_A200);
		repeat (10) @(posedge clk_sys_i);
		chk("sent", 0, phy.sent);
		system_idle_i <= 1'b0;
		wait_until(1);
		repeat (10) @(posedge clk_sys_i);
		chk("irq", 1, irq_o);
		wr(8'h30, 32'h1, 4'hF);
		phy.frame(1'b1, 1'b0, 3);
		repeat (3) @(posedge clk_sys_i);
		chk("stored", 0, stored);
		wr(8'h00, 32'h0000_8100, 4'hF);
		for (int i = 0; i < 3; i++) begin
			fork
				phy.frame(i == 0, i == 2, 6);
				begin
					repeat (3) @(posedge clk_sys_i);
					rchk("status", 8'h10, 32'h20);
				end
			join
			repeat (3) @(posedge clk_sys_i);
			rchk("status", 8'h10, 32'h0);
			chk("stored", 1, stored);
		end
		rchk("irq status", 8'h30, 32'h6);
		fork
			phy.frame(1'b1, 1'b0, 8);
			begin
				repeat (4) @(posedge clk_sys_i);
				wr(8'h00, 32'h0, 4'hF);
				rchk("status", 8'h10, 32'h0);
			end
		join
		chk("stored", 1, stored);
		wr(8'h00, 32'h0000_8100, 4'hF);
		phy.frame(1'b1, 1'b0, 3);
		repeat (3) @(posedge clk_sys_i);
		chk("stored", 2, stored);
		tally_and_finish;
	end
endmodule
bind ethernet_mac_control ethernet_mac_control_props props (.clk_sys_i(clk_sys_i),
	.reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .byte_en_i(byte_en_i),
	.write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
	.tx_descriptor_valid_i(tx_descriptor_valid_i), .rx_frame_end_i(rx_frame_end_i),
	.rx_filter_pass_i(rx_filter_pass_i), .tx_packet_start_o(tx_packet_start_o),
	.rx_store_o(rx_store_o), .pause_time_value_o(pause_time_value_o));
